// ---- verilog/uef_error_flags.sv ----
// USB error status flags with write-one-to-clear register port and interrupt.
// Assumes event inputs are one-cycle pulses or levels synchronous to clk.
`timescale 1ns/1ps
module uef_error_flags
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire uef_event_t evt,
   output logic packet_discard,
   output logic host_mode,
   output logic irq
);

   // ----------------------------------------
   // Event decode
   // ----------------------------------------
   logic [UEF_NFLAGS-1:0] set_vec;
   logic [UEF_NFLAGS-1:0] clr_vec;
   logic [UEF_NFLAGS-1:0] flags_r;
   logic [UEF_NFLAGS-1:0] mask_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic host_r;
   logic bit_tick;
   logic timeout;
   logic eof_hit;
   logic err_any;

   uef_bit_timer u_bit_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .restart(evt.eop_seen),
      .bit_tick(bit_tick)
   );

   uef_turnaround u_turnaround (
      .clk(clk),
      .sys_rst(sys_rst),
      .eop_seen(evt.eop_seen),
      .expect_resp(evt.expect_resp),
      .resp_start(evt.resp_start),
      .bit_tick(bit_tick),
      .timeout(timeout)
   );

   assign eof_hit = host_r && evt.xfer_active && evt.sof_zero; // RULE10

   always_comb begin
      set_vec = '0;
      set_vec[UEF_BIT_STUFF] = evt.bit_stuff_err; // RULE1
      set_vec[UEF_BIT_ADDR] = evt.bad_table_base | evt.bad_buffer_addr; // RULE2
      set_vec[UEF_BIT_DMA] = evt.dma_fault // RULE3
         | evt.dma_late_grant // RULE4
         | evt.rx_truncated; // RULE5
      set_vec[UEF_BIT_TOUT] = timeout; // RULE6
      set_vec[UEF_BIT_DFN] = evt.dfn_err; // RULE8
      set_vec[UEF_BIT_CRC16] = evt.crc16_err; // RULE9
      // Shared bit: token check in device mode, frame overrun in host mode
      set_vec[UEF_BIT_TOKEOF] = host_r ? eof_hit : evt.token_crc5_err; // RULE13
      set_vec[UEF_BIT_PID] = evt.pid_err; // RULE13
   end

   assign clr_vec = (reg_wr && reg_addr == UEF_ADDR_FLAGS) ?
      reg_wdata[UEF_NFLAGS-1:0] : '0; // RULE11
   assign err_any = |set_vec;

   // ----------------------------------------
   // Flag bits, set wins over clear
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < UEF_NFLAGS; gi = gi + 1) begin : g_flag
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               flags_r[gi] <= UEF_FLAGS_RST[gi]; // RULE13
            end else if (set_vec[gi]) begin
               flags_r[gi] <= 1'b1; // RULE11
            end else if (clr_vec[gi]) begin
               flags_r[gi] <= 1'b0; // RULE11
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Packet rejection strobe
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         packet_discard <= 1'b0;
      end else begin
         packet_discard <= evt.bit_stuff_err | evt.crc16_err; // RULE1 RULE9
      end
   end

   // ----------------------------------------
   // Control and masks
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_r <= UEF_MASK_RST;
         irq_mask_r <= UEF_IRQ_RST;
         host_r <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == UEF_ADDR_MASK) begin
            mask_r <= reg_wdata[UEF_NFLAGS-1:0];
         end
         if (reg_addr == UEF_ADDR_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[1:0];
         end
         if (reg_addr == UEF_ADDR_CTRL) begin
            host_r <= reg_wdata[UEF_CTRL_HOST];
         end
      end
   end

   assign host_mode = host_r;

   // ----------------------------------------
   // Interrupt status: bit 0 any error, bit 1 time-out
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_r <= UEF_IRQ_RST;
      end else begin
         irq_stat_r[0] <= err_any | (irq_stat_r[0] &
            ~(reg_wr && reg_addr == UEF_ADDR_IRQ_STAT && reg_wdata[0]));
         irq_stat_r[1] <= timeout | (irq_stat_r[1] &
            ~(reg_wr && reg_addr == UEF_ADDR_IRQ_STAT && reg_wdata[1]));
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(flags_r & mask_r)) | (|(irq_stat_r & irq_mask_r));
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= UEF_RD_UNMAPPED;
      end else if (reg_rd) begin
         case (reg_addr)
            UEF_ADDR_FLAGS: reg_rdata <= {24'h000000, flags_r}; // RULE12
            UEF_ADDR_MASK: reg_rdata <= {24'h000000, mask_r};
            UEF_ADDR_IRQ_STAT: reg_rdata <= {30'h00000000, irq_stat_r};
            UEF_ADDR_IRQ_MASK: reg_rdata <= {30'h00000000, irq_mask_r};
            UEF_ADDR_CTRL: reg_rdata <= {31'h00000000, host_r};
            default: reg_rdata <= UEF_RD_UNMAPPED;
         endcase
      end else begin
         reg_rdata <= UEF_RD_UNMAPPED;
      end
   end

endmodule

// ---- verilog/uef_pkg.sv ----
// Constants, types and register map of the USB error status flag block.
// Assumes one 125 MHz clock and a simple strobe register port.
// Function
// RULE1: Bit stuffing violation discards packet, sets flag bit 7.
// RULE2: Invalid descriptor table base or buffer address sets flag bit 6.
// RULE3: Any USB DMA path error sets flag bit 5.
// RULE4: Late memory bus grant causing overflow or underflow sets bit 5.
// RULE5: Received packet truncated by too small buffer sets bit 5.
// RULE6: Missing response in time sets turnaround time-out flag bit 4.
// RULE7: Time-out declared after more than 16 idle bit-times since last end-of-packet.
// RULE8: Data field not a whole number of bytes sets flag bit 3.
// RULE9: Data packet with failed CRC16 is rejected, sets flag bit 2.
// RULE10: Host mode, busy when frame countdown hits zero sets end-of-frame flag.
// RULE11: Hardware sets flags; writing one clears, writing zero leaves unchanged.
// RULE12: Bits 31 to 8 of the flag register read as zero.
// RULE13: Bit 1 token check or end-of-frame by mode, bit 0 packet id; reset zero.
package uef_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] UEF_ADDR_FLAGS = 8'h00;
   localparam logic [7:0] UEF_ADDR_MASK = 8'h04;
   localparam logic [7:0] UEF_ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] UEF_ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] UEF_ADDR_CTRL = 8'h10;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int UEF_BIT_STUFF = 7;
   localparam int UEF_BIT_ADDR = 6;
   localparam int UEF_BIT_DMA = 5;
   localparam int UEF_BIT_TOUT = 4;
   localparam int UEF_BIT_DFN = 3;
   localparam int UEF_BIT_CRC16 = 2;
   localparam int UEF_BIT_TOKEOF = 1;
   localparam int UEF_BIT_PID = 0;
   localparam int UEF_NFLAGS = 8;
   localparam int UEF_CTRL_HOST = 0;
   localparam logic [7:0] UEF_FLAGS_RST = 8'h00;
   localparam logic [7:0] UEF_MASK_RST = 8'h00;
   localparam logic [1:0] UEF_IRQ_RST = 2'h0;
   localparam logic [31:0] UEF_RD_UNMAPPED = 32'h0000_0000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int UEF_CLK_MHZ = 125;
   localparam int UEF_BIT_NS_X10 = 833;
   localparam int UEF_BIT_CYC = (UEF_BIT_NS_X10 * UEF_CLK_MHZ + 9999) / 10000;
   localparam logic [3:0] UEF_BIT_CYC_M1 = 4'(UEF_BIT_CYC - 1);
   localparam logic [4:0] UEF_TOUT_BITS = 5'h10;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic bit_stuff_err;
      logic bad_table_base;
      logic bad_buffer_addr;
      logic dma_fault;
      logic dma_late_grant;
      logic rx_truncated;
      logic eop_seen;
      logic expect_resp;
      logic resp_start;
      logic dfn_err;
      logic crc16_err;
      logic token_crc5_err;
      logic xfer_active;
      logic sof_zero;
      logic pid_err;
   } uef_event_t;

   typedef enum logic [1:0] {
      UEF_TO_IDLE = 2'b00,
      UEF_TO_WAIT = 2'b01,
      UEF_TO_FIRED = 2'b10
   } uef_to_state_t;

endpackage

// ---- verilog/uef_bit_timer.sv ----
// Bit-time enable divider for the full-speed link.
// Assumes the 125 MHz system clock.
`timescale 1ns/1ps
module uef_bit_timer
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic restart,
   output logic bit_tick
);

   logic [3:0] div_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r <= 4'h0;
         bit_tick <= 1'b0;
      end else if (restart) begin
         div_r <= 4'h0;
         bit_tick <= 1'b0;
      end else if (div_r == UEF_BIT_CYC_M1) begin
         div_r <= 4'h0;
         bit_tick <= 1'b1;
      end else begin
         div_r <= div_r + 4'h1;
         bit_tick <= 1'b0;
      end
   end

endmodule

// ---- verilog/uef_turnaround.sv ----
// Bus turnaround time-out watcher.
// Assumes bit_tick pulses once per full-speed bit time.
`timescale 1ns/1ps
module uef_turnaround
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic eop_seen,
   input wire logic expect_resp,
   input wire logic resp_start,
   input wire logic bit_tick,
   output logic timeout
);

   uef_to_state_t state_r;
   logic [4:0] idle_bits_r;

   // Counts idle bit-times since the last end-of-packet
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= UEF_TO_IDLE;
         idle_bits_r <= 5'h00;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         case (state_r)
            UEF_TO_IDLE: begin
               if (eop_seen && expect_resp) begin
                  state_r <= UEF_TO_WAIT;
                  idle_bits_r <= 5'h00;
               end
            end
            UEF_TO_WAIT: begin
               if (resp_start) begin
                  state_r <= UEF_TO_IDLE;
               end else if (eop_seen) begin
                  idle_bits_r <= 5'h00; // RULE7
               end else if (bit_tick) begin
                  if (idle_bits_r == UEF_TOUT_BITS) begin
                     state_r <= UEF_TO_FIRED; // RULE7
                     timeout <= 1'b1; // RULE6
                  end else begin
                     idle_bits_r <= idle_bits_r + 5'h01;
                  end
               end
            end
            UEF_TO_FIRED: begin
               state_r <= UEF_TO_IDLE;
            end
            default: begin
               state_r <= UEF_TO_IDLE;
            end
         endcase
      end
   end

endmodule

// ---- dv/uef_checker.sv ----
// Port assertions for the USB error flag block.
// Assumes the one-cycle register read timing of the block.
`timescale 1ns/1ps
module uef_checker
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire uef_event_t evt,
   input wire logic packet_discard,
   input wire logic host_mode,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic rf;
   logic dsc;
   assign rf = reg_rd && reg_addr == UEF_ADDR_FLAGS;
   assign dsc = evt.bit_stuff_err || evt.crc16_err;
   property p_discard;
      dsc |=> packet_discard;
   endproperty
   a_discard: assert property (p_discard) else $error("no discard");
   property p_keep;
      !dsc |=> !packet_discard;
   endproperty
   a_keep: assert property (p_keep) else $error("stray discard");
   property p_upper;
      reg_rd |=> reg_rdata[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_stuff;
      evt.bit_stuff_err ##1 !reg_wr ##1 rf |=> reg_rdata[UEF_BIT_STUFF];
   endproperty
   a_stuff: assert property (p_stuff) else $error("stuff flag");
   property p_addr;
      (evt.bad_table_base || evt.bad_buffer_addr) ##1 !reg_wr ##1 rf |=> reg_rdata[UEF_BIT_ADDR];
   endproperty
   a_addr: assert property (p_addr) else $error("address flag");
   property p_dma;
      (evt.dma_fault || evt.dma_late_grant || evt.rx_truncated) ##1 !reg_wr ##1 rf
         |=> reg_rdata[UEF_BIT_DMA];
   endproperty
   a_dma: assert property (p_dma) else $error("dma flag");
   property p_crc;
      evt.crc16_err ##1 !reg_wr ##1 rf |=> reg_rdata[UEF_BIT_CRC16];
   endproperty
   a_crc: assert property (p_crc) else $error("crc flag");
   property p_dfn;
      evt.dfn_err ##1 !reg_wr ##1 rf |=> reg_rdata[UEF_BIT_DFN];
   endproperty
   a_dfn: assert property (p_dfn) else $error("size flag");
   property p_clear;
      reg_wr && reg_addr == UEF_ADDR_FLAGS && reg_wdata[UEF_BIT_PID] && !evt.pid_err
         ##1 !evt.pid_err ##1 rf && !evt.pid_err |=> !reg_rdata[UEF_BIT_PID];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule
bind uef_error_flags uef_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .evt(evt), .packet_discard(packet_discard), .host_mode(host_mode), .irq(irq));

// ---- dv/uef_link_partner.sv ----
// Far end of the link: error pulses and a response after a set lag.
// Assumes the bench raises send for one cycle per packet.
`timescale 1ns/1ps
module uef_link_partner
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [14:0] err_pulse,
   input wire logic send,
   input wire logic [15:0] lag,
   output uef_event_t evt
);
   logic [15:0] cnt_r;
   logic wait_r;
   // Response lag after end of packet
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 16'h0;
         wait_r <= 1'b0;
      end else if (send) begin
         cnt_r <= lag;
         wait_r <= 1'b1;
      end else if (wait_r && cnt_r != 16'h0) begin
         cnt_r <= cnt_r - 16'h1;
      end else begin
         wait_r <= 1'b0;
      end
   end
   always_comb begin
      evt = uef_event_t'(err_pulse);
      evt.eop_seen = send;
      evt.expect_resp = wait_r | send;
      evt.resp_start = wait_r && cnt_r == 16'h1;
   end
endmodule

// ---- dv/tb_usb_error_status_flags.sv ----
// Self-checking bench for the USB error flag block.
// Assumes the link partner model and the port checker.
`timescale 1ns/1ps
module tb_usb_error_status_flags;
   import uef_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [14:0] err_pulse = 15'h0;
   logic send = 1'b0;
   logic [15:0] lag = 16'h0;
   logic packet_discard;
   logic host_mode;
   logic irq;
   uef_event_t evt;
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 20;
   int mf = 0;
   int fld[10] = '{14, 13, 12, 11, 10, 9, 5, 4, 3, 0};
   int bt[10] = '{7, 6, 6, 5, 5, 5, 3, 2, 1, 0};
   always #4 clk = ~clk;
   uef_error_flags u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .evt(evt), .packet_discard(packet_discard), .host_mode(host_mode), .irq(irq));
   uef_link_partner u_far (.clk(clk), .sys_rst(sys_rst), .err_pulse(err_pulse),
      .send(send), .lag(lag), .evt(evt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic pulse(input logic [14:0] m);
      @(posedge clk);
      err_pulse <= m;
      @(posedge clk);
      err_pulse <= 15'h0;
   endtask
   task automatic xfer(input logic [15:0] l);
      @(posedge clk);
      send <= 1'b1;
      lag <= l;
      @(posedge clk);
      send <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      logic [31:0] d;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h0);
      rd(8'h40, d);
      chk(d, 32'h0);
      for (int i = 0; i < 10; i++) begin
         pulse(15'(1 << fld[i]));
         mf = mf | (1 << bt[i]);
         rd(UEF_ADDR_FLAGS, d);
         chk(d, 32'(mf));
         wr(UEF_ADDR_FLAGS, $random(seed) & 32'hffff_ff00);
         rd(UEF_ADDR_FLAGS, d);
         chk(d, 32'(mf));
         if (i > 0) begin
            wr(UEF_ADDR_FLAGS, 32'(1 << bt[i - 1]) | ($random(seed) & 32'hffff_ff00));
            mf = mf & ~(1 << bt[i - 1]);
            rd(UEF_ADDR_FLAGS, d);
            chk(d, 32'(mf));
         end
      end
      wr(UEF_ADDR_FLAGS, 32'hff);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h0);
      @(posedge clk);
      err_pulse <= 15'h1;
      reg_wr <= 1'b1;
      reg_wdata <= 32'h1;
      @(posedge clk);
      err_pulse <= 15'h0;
      reg_wr <= 1'b0;
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h1);
      wr(UEF_ADDR_CTRL, 32'h1);
      wr(UEF_ADDR_FLAGS, 32'h1);
      chk(32'(host_mode), 32'h1);
      pulse(15'h8);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h0);
      pulse(15'h6);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h2);
      wr(UEF_ADDR_CTRL, 32'h0);
      wr(UEF_ADDR_FLAGS, 32'hff);
      xfer(16'd165);
      repeat (250) @(posedge clk);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h0);
      xfer(16'd400);
      // Seventeenth idle bit lands 188 cycles after end-of-packet
      repeat (183) @(posedge clk);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h0);
      repeat (8) @(posedge clk);
      rd(UEF_ADDR_FLAGS, d);
      chk(d, 32'h10);
      repeat (200) @(posedge clk);
      wr(UEF_ADDR_FLAGS, 32'hff);
      wr(UEF_ADDR_MASK, 32'h4);
      pulse(15'h1);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      pulse(15'h10);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h1);
      wr(UEF_ADDR_FLAGS, 32'h5);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      wrap_up();
   end
endmodule
